// file: verif/tb_top.sv
// Self-checking bench of the watchdog control block
`include "wdc_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, por_n, clkEn, vectorFetch, err;
  logic        psel, penable, pwrite, pready, pslverr, wdogIrq, forceReset;
  logic [2:0]  modes;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, tests_run;
  wdc_top dut_u (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .clkEn(clkEn),
    .debugMode(modes[2]), .waitMode(modes[1]), .stopMode(modes[0]),
    .vectorFetch(vectorFetch), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdogIrq(wdogIrq), .forceReset(forceReset)
  );
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(logic wr, logic [11:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    if (i >= 20) begin
      n_errors++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_rst(logic p);
    modes <= 3'b111;
    rst_n <= 1'b0;
    por_n <= ~p;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
  endtask
  task automatic trip(logic [7:0] c, logic [15:0] t, logic [2:0] m, int lo, int hi);
    int n;
    do_rst(1'b1);
    xfer(1'b1, `WDC_OFF_TIMEOUT, {16'h0000, t});
    xfer(1'b1, `WDC_OFF_CTRL1, {24'h00_0000, c});
    modes <= m;
    repeat (lo) @(posedge clock);
    chk("early reset", 32'h0, 32'(forceReset));
    n = lo;
    while (hi > 0 && forceReset !== 1'b1 && n < hi) begin
      @(posedge clock);
      n++;
    end
    if (hi > 0) chk("timeout reset", 32'h1, 32'(forceReset));
  endtask
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    clkEn = 1'b1;
    vectorFetch = 1'b0;
    modes = 3'b111;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    do_rst(1'b1);
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("ctrl1 reset", 32'h0000_0080, rd);
    xfer(1'b0, `WDC_OFF_TIMEOUT, 32'h0000_0000);
    chk("timeout reset", 32'h0000_0004, rd);
    xfer(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped", 32'h1, 32'(err));
    clkEn <= 1'b0;
    repeat (4) @(posedge clock);
    clkEn <= 1'b1;
    xfer(1'b1, `WDC_OFF_IRQ_MASK, 32'h0000_0040);
    xfer(1'b1, `WDC_OFF_TIMEOUT, 32'h0000_FFFF);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_00E8);
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("ctrl1 first", 32'h0000_00E8, rd);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_20C5);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_28D9);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_00EC);
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("ctrl1 unlocked", 32'h0000_00EC, rd);
    chk("no reset", 32'h0, 32'(forceReset));
    modes <= 3'b000;
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_02A6);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_80B4);
    xfer(1'b0, `WDC_OFF_COUNT, 32'h0000_0000);
    chk("refreshed count", 32'h0000_0001, rd);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_1234);
    chk("irq", 32'h1, 32'(wdogIrq));
    chk("held reset", 32'h0, 32'(forceReset));
    xfer(1'b0, `WDC_OFF_CTRL2, 32'h0000_0000);
    chk("flag", 32'h0000_0040, rd & 32'h0000_0040);
    xfer(1'b1, `WDC_OFF_IRQ_MASK, 32'h0000_0000);
    chk("masked irq", 32'h0, 32'(wdogIrq));
    xfer(1'b1, `WDC_OFF_IRQ_MASK, 32'h0000_0040);
    chk("unmasked irq", 32'h1, 32'(wdogIrq));
    xfer(1'b1, `WDC_OFF_IRQ_STAT, 32'h0000_0040);
    chk("cleared irq", 32'h0, 32'(wdogIrq));
    vectorFetch <= 1'b1;
    @(posedge clock);
    vectorFetch <= 1'b0;
    repeat (120) @(posedge clock);
    chk("early delay", 32'h0, 32'(forceReset));
    repeat (12) @(posedge clock);
    chk("delayed reset", 32'h1, 32'(forceReset));
    do_rst(1'b0);
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("test kept", 32'h0000_0088, rd);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_0088);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_0080);
    @(posedge clock);
    chk("locked reset", 32'h1, 32'(forceReset));
    chk("no irq", 32'h0, 32'(wdogIrq));
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("ctrl1 kept", 32'h0000_0088, rd);
    do_rst(1'b1);
    xfer(1'b0, `WDC_OFF_CTRL1, 32'h0000_0000);
    chk("test cleared", 32'h0000_0080, rd);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_00A0);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_20C5);
    repeat (20) @(posedge clock);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_28D9);
    @(posedge clock);
    chk("late key", 32'h1, 32'(forceReset));
    do_rst(1'b0);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_00A0);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_20C5);
    xfer(1'b1, `WDC_OFF_COUNT, 32'h0000_28D9);
    xfer(1'b0, `WDC_OFF_STATUS, 32'h0000_0000);
    chk("status open", 32'h0000_000C, rd);
    repeat (130) @(posedge clock);
    xfer(1'b0, `WDC_OFF_STATUS, 32'h0000_0000);
    chk("status shut", 32'h0000_0004, rd);
    xfer(1'b1, `WDC_OFF_CTRL1, 32'h0000_00A0);
    @(posedge clock);
    chk("window shut", 32'h1, 32'(forceReset));
    trip(8'h88, 16'h0040, 3'b000, 40, 120);
    trip(8'h90, 16'h0F40, 3'b000, 40, 150);
    trip(8'h98, 16'h02FF, 3'b000, 450, 600);
    trip(8'h00, 16'h0004, 3'b000, 200, 0);
    trip(8'h80, 16'h0020, 3'b100, 200, 0);
    trip(8'h84, 16'h0020, 3'b100, 10, 150);
    trip(8'h80, 16'h0020, 3'b010, 200, 0);
    trip(8'h82, 16'h0020, 3'b010, 10, 150);
    trip(8'h80, 16'h0020, 3'b001, 200, 0);
    trip(8'h81, 16'h0020, 3'b001, 10, 150);
    test_done();
  end
endmodule

// file: verif/wdc_top_monitor.sv
// Port checker of the watchdog control block
module wdc_top_monitor (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        vectorFetch,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        wdogIrq,
  input  wire logic        forceReset
);
  logic [7:0] fetchAge;
  logic [7:0] next_fetchAge;
  // Cycles since the last vector fetch, saturating
  always_comb begin
    next_fetchAge = fetchAge;
    if (clkEn && vectorFetch) begin
      next_fetchAge = 8'h00;
    end else if (clkEn && fetchAge != 8'hFF) begin
      next_fetchAge = fetchAge + 8'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetchAge <= 8'hFF;
    end else begin
      fetchAge <= next_fetchAge;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_forceRise;
    $rose(forceReset) && fetchAge != 8'hFF;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (s_access ##0 (paddr > 12'h018) |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (s_access ##0 (paddr <= 12'h018 && paddr[1:0] == 2'b00)
    |-> !pslverr) else $error("error on mapped access");
  a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");
  a_force_holds: assert property (forceReset |=> forceReset)
    else $error("forced reset released");
  a_irq_first: assert property ($rose(wdogIrq) |-> !forceReset ##1 !forceReset)
    else $error("reset not delayed after interrupt");
  a_freeze_state: assert property (!clkEn |=> $stable(forceReset) && $stable(wdogIrq))
    else $error("state moved while frozen");
  a_delay_exact: assert property (s_forceRise |-> fetchAge == 8'd128)
    else $error("reset delay after fetch wrong");
endmodule

bind wdc_top wdc_top_monitor mon_u (
  .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .vectorFetch(vectorFetch),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdogIrq(wdogIrq),
  .forceReset(forceReset)
);

// file: verilog/wdc_cmp_if.sv
// Counter compare signals between the controller and the compare unit
interface wdc_cmp_if;
  logic [15:0]          count;
  logic [15:0]          timeout;
  wdc_pkg::wdc_tst_e    mode;
  logic                 hit;
  modport ctrl (output count, output timeout, output mode, input hit);
  modport cmp  (input count, input timeout, input mode, output hit);
endinterface

// file: verilog/wdc_compare.sv
// Timeout compare unit with byte-wise test modes
module wdc_compare (
  wdc_cmp_if.cmp cmp
);
  always_comb begin
    case (cmp.mode)
      wdc_pkg::WDC_TST_LOW:  cmp.hit = (cmp.count[7:0] == cmp.timeout[7:0]);
      wdc_pkg::WDC_TST_HIGH: cmp.hit = (cmp.count[15:8] == cmp.timeout[15:8]);
      default:               cmp.hit = (cmp.count >= cmp.timeout);
    endcase
  end
endmodule

// file: verilog/wdc_map.svh
// Offsets, field positions, reset values and timing counts of the watchdog control block
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH
`define WDC_OFF_CTRL1      12'h000
`define WDC_OFF_CTRL2      12'h004
`define WDC_OFF_COUNT      12'h008
`define WDC_OFF_TIMEOUT    12'h00C
`define WDC_OFF_IRQ_STAT   12'h010
`define WDC_OFF_IRQ_MASK   12'h014
`define WDC_OFF_STATUS     12'h018
`define WDC_BIT_EN         7
`define WDC_BIT_INT        6
`define WDC_BIT_UPDATE     5
`define WDC_TST_HI         4
`define WDC_TST_LO         3
`define WDC_BIT_DBG        2
`define WDC_BIT_WAIT       1
`define WDC_BIT_STOP       0
`define WDC_CTRL1_RESET    8'h80
`define WDC_TIMEOUT_RESET  16'h0004
`define WDC_FLAG_BIT       6
`define WDC_UNLOCK_KEY1    16'h20C5
`define WDC_UNLOCK_KEY2    16'h28D9
`define WDC_REFRESH_KEY1   16'h02A6
`define WDC_REFRESH_KEY2   16'h80B4
`define WDC_CLK_MHZ        200
`define WDC_DELAY_BUS_CLKS 128
`define WDC_DELAY_CYCLES   8'd128
`define WDC_KEY_GAP_CYCLES 5'd16
`define WDC_OPEN_CYCLES    8'd128
`endif

// file: verilog/wdc_pkg.sv
// Types shared by the watchdog control block
package wdc_pkg;
  typedef enum logic [1:0] {
    WDC_RUN,
    WDC_IRQ_WAIT,
    WDC_DELAY,
    WDC_RESET
  } wdc_state_e;
  typedef enum logic [1:0] {
    WDC_TST_OFF,
    WDC_TST_USER,
    WDC_TST_LOW,
    WDC_TST_HIGH
  } wdc_tst_e;
endpackage

// file: verilog/wdc_top.sv
// Watchdog control register one with counter, unlock and forced-reset sequencing
//
// Our own choice: register access over APB.
`include "wdc_map.svh"

module wdc_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        clkEn,
  input  wire logic        debugMode,
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  input  wire logic        vectorFetch,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             wdogIrq,
  output logic             forceReset
);
  wdc_cmp_if cmpBus ();
  wdc_compare uCompare (.cmp(cmpBus.cmp));

  logic [7:0]  ctrl1, next_ctrl1;
  logic [1:0]  tst, next_tst;
  logic        configured, next_configured;
  logic        tstWritten, next_tstWritten;
  logic [15:0] counter, next_counter;
  logic [15:0] timeoutVal, next_timeoutVal;
  logic        flag, next_flag;
  logic        irqMask, next_irqMask;
  logic [4:0]  keyGap, next_keyGap;
  logic        keyArmed, next_keyArmed;
  logic [1:0]  keyKind, next_keyKind;
  logic [7:0]  openCnt, next_openCnt;
  logic [7:0]  delayCnt, next_delayCnt;
  logic        resetReq, next_resetReq;
  logic [31:0] readData, next_readData;
  wdc_pkg::wdc_state_e state, next_state;

  logic wrAccess, rdAccess, goodAddr, running, event_, illegal, unlocked;
  logic [7:0] ctrlWr;

  function automatic logic addrOk(input logic [11:0] a);
    addrOk = (a == `WDC_OFF_CTRL1) || (a == `WDC_OFF_CTRL2) || (a == `WDC_OFF_COUNT) ||
             (a == `WDC_OFF_TIMEOUT) || (a == `WDC_OFF_IRQ_STAT) ||
             (a == `WDC_OFF_IRQ_MASK) || (a == `WDC_OFF_STATUS);
  endfunction

  // First word of either two-step key sequence
  function automatic logic firstKey(input logic [15:0] w);
    firstKey = (w == `WDC_UNLOCK_KEY1) || (w == `WDC_REFRESH_KEY1);
  endfunction

  assign pready   = 1'b1;
  assign goodAddr = addrOk(paddr);
  assign pslverr  = psel && penable && !goodAddr;
  assign wrAccess = psel && penable && pwrite && goodAddr && clkEn;
  assign rdAccess = psel && !penable && !pwrite && clkEn;
  assign prdata   = readData;
  assign wdogIrq  = flag && irqMask;
  assign forceReset = resetReq;
  assign ctrlWr   = pwdata[7:0];
  assign unlocked = openCnt != 8'd0;

  // Suspend in low-power and debug modes unless allowed
  assign running = ctrl1[`WDC_BIT_EN] &&
                   !(debugMode && !ctrl1[`WDC_BIT_DBG]) &&
                   !(waitMode && !ctrl1[`WDC_BIT_WAIT]) &&
                   !(stopMode && !ctrl1[`WDC_BIT_STOP]);

  assign cmpBus.count   = counter;
  assign cmpBus.timeout = timeoutVal;
  assign cmpBus.mode    = wdc_pkg::wdc_tst_e'(tst);

  // Reconfiguring while locked, or writing a bad key to the counter
  always_comb begin
    illegal = 1'b0;
    if (wrAccess && (paddr == `WDC_OFF_CTRL1 || paddr == `WDC_OFF_TIMEOUT)) begin
      if (configured && !unlocked) illegal = 1'b1;
    end
    if (wrAccess && paddr == `WDC_OFF_COUNT) begin
      if (!(firstKey(pwdata[15:0]) ||
            (keyArmed && pwdata[15:0] == `WDC_UNLOCK_KEY2 && keyKind == 2'd1) ||
            (keyArmed && pwdata[15:0] == `WDC_REFRESH_KEY2 && keyKind == 2'd2)))
        illegal = 1'b1;
    end
  end

  assign event_ = (running && cmpBus.hit) || illegal;

  always_comb begin
    next_ctrl1         = ctrl1;
    next_tst           = tst;
    next_configured    = configured;
    next_tstWritten    = tstWritten;
    next_counter       = counter;
    next_timeoutVal    = timeoutVal;
    next_flag          = flag;
    next_irqMask       = irqMask;
    next_keyGap        = keyGap;
    next_keyArmed      = keyArmed;
    next_keyKind       = keyKind;
    next_openCnt       = openCnt;
    next_delayCnt      = delayCnt;
    next_resetReq      = resetReq;
    next_state         = state;

    if (running && state == wdc_pkg::WDC_RUN) next_counter = counter + 16'h0001;
    if (unlocked) next_openCnt = openCnt - 8'd1;

    if (keyArmed) begin
      if (keyGap == 5'd0) next_keyArmed = 1'b0;
      else next_keyGap = keyGap - 5'd1;
    end

    if (wrAccess) begin
      case (paddr)
        `WDC_OFF_CTRL1: if (!illegal) begin
          next_ctrl1 = ctrlWr;
          next_configured = 1'b1;
          if (!tstWritten || unlocked) begin
            next_tst = ctrlWr[`WDC_TST_HI:`WDC_TST_LO];
            next_tstWritten = 1'b1;
          end
        end
        `WDC_OFF_TIMEOUT: if (!illegal) next_timeoutVal = pwdata[15:0];
        `WDC_OFF_COUNT: begin
          if (firstKey(pwdata[15:0])) begin
            next_keyArmed = 1'b1;
            next_keyGap   = `WDC_KEY_GAP_CYCLES - 5'd1;
            next_keyKind  = (pwdata[15:0] == `WDC_UNLOCK_KEY1) ? 2'd1 : 2'd2;
          end else if (!illegal) begin
            next_keyArmed = 1'b0;
            if (keyKind == 2'd1 && ctrl1[`WDC_BIT_UPDATE]) next_openCnt = `WDC_OPEN_CYCLES;
            if (keyKind == 2'd2) next_counter = 16'h0000;
          end
        end
        `WDC_OFF_IRQ_STAT: if (pwdata[`WDC_FLAG_BIT]) next_flag = 1'b0;
        `WDC_OFF_IRQ_MASK: next_irqMask = pwdata[`WDC_FLAG_BIT];
        default: ;
      endcase
    end

    case (state)
      wdc_pkg::WDC_RUN: if (event_) begin
        if (ctrl1[`WDC_BIT_INT]) begin
          next_flag  = 1'b1;
          next_state = wdc_pkg::WDC_IRQ_WAIT;
        end else begin
          next_resetReq = 1'b1;
          next_state = wdc_pkg::WDC_RESET;
        end
      end
      wdc_pkg::WDC_IRQ_WAIT: if (vectorFetch) begin
        next_delayCnt = `WDC_DELAY_CYCLES - 8'd1;
        next_state = wdc_pkg::WDC_DELAY;
      end
      wdc_pkg::WDC_DELAY: if (delayCnt == 8'd0) begin
        next_resetReq = 1'b1;
        next_state = wdc_pkg::WDC_RESET;
      end else begin
        next_delayCnt = delayCnt - 8'd1;
      end
      wdc_pkg::WDC_RESET: next_resetReq = 1'b1;
      default: next_state = wdc_pkg::WDC_RUN;
    endcase

  end

  // Read data is latched in the setup cycle and held until the next read
  always_comb begin
    next_readData = readData;
    if (rdAccess) begin
      case (paddr)
        `WDC_OFF_CTRL1: next_readData = {24'h00_0000, ctrl1[7:5], tst, ctrl1[2:0]};
        `WDC_OFF_CTRL2, `WDC_OFF_IRQ_STAT: next_readData = {24'h00_0000, 1'b0, flag, 6'h00};
        `WDC_OFF_COUNT: next_readData = {16'h0000, counter};
        `WDC_OFF_TIMEOUT: next_readData = {16'h0000, timeoutVal};
        `WDC_OFF_IRQ_MASK: next_readData = {24'h00_0000, 1'b0, irqMask, 6'h00};
        `WDC_OFF_STATUS: next_readData = {28'h000_0000, unlocked, configured, state};
        default: next_readData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 32'h0000_0000;
    end else if (clkEn) begin
      readData <= next_readData;
    end
  end

  // Test field is held across all resets except power-on
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      tst        <= 2'b00;
      tstWritten <= 1'b0;
    end else if (clkEn) begin
      tst        <= next_tst;
      tstWritten <= next_tstWritten;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1         <= `WDC_CTRL1_RESET;
      configured    <= 1'b0;
      counter       <= 16'h0000;
      timeoutVal    <= `WDC_TIMEOUT_RESET;
      flag          <= 1'b0;
      irqMask       <= 1'b0;
      keyGap        <= 5'd0;
      keyArmed      <= 1'b0;
      keyKind       <= 2'd0;
      openCnt       <= 8'd0;
      delayCnt      <= 8'd0;
      resetReq      <= 1'b0;
      state         <= wdc_pkg::WDC_RUN;
    end else if (clkEn) begin
      ctrl1         <= next_ctrl1;
      configured    <= next_configured;
      counter       <= next_counter;
      timeoutVal    <= next_timeoutVal;
      flag          <= next_flag;
      irqMask       <= next_irqMask;
      keyGap        <= next_keyGap;
      keyArmed      <= next_keyArmed;
      keyKind       <= next_keyKind;
      openCnt       <= next_openCnt;
      delayCnt      <= next_delayCnt;
      resetReq      <= next_resetReq;
      state         <= next_state;
    end
  end
endmodule
